/* File: ascc_top.sv */
// register bank and control for channel scan, crossing hold-off and alarm masking
// assumes an apb master on core_clk and a converter reporting each finished conversion
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
//Behaviour
// - multiplier bit scales hold-off count by eight
// - hold-off counts only crossing-channel conversions
// - hold-off counting starts at crossing detection
// - scan run converts enabled channels ascending
// - mode field: manual, auto, on-the-fly, reserved
// - reserved scan config bits read zero
// - upper channel code picks crossing input
// - digital crossing channel passes pin level
// - manual mode converts lower channel code
// - scan includes only channels with mask bit
// - alarm flags pass only with mask bit
// - pin-function zero analog, one digital
module ascc_top
  import ascc_pkg::*;
#(
  parameter int NCH = NUM_CHAN
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [CHAN_CODE_W-1:0] conv_channel,
  input wire logic [NCH-1:0] analog_crossing,
  input wire logic [NCH-1:0] pin_level,
  input wire logic [NCH-1:0] alarm_flags,
  input wire logic [CHAN_CODE_W-1:0] fly_channel_code,
  output logic [CHAN_CODE_W-1:0] next_channel,
  output logic scan_active,
  output logic zero_crossing_detect,
  output logic crossing_blanking,
  output logic alarm_out,
  output logic irq
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] holdoff_reg, holdoff_next;
  logic [7:0] scan_config_reg, scan_config_next;
  logic [7:0] channel_pick_reg, channel_pick_next;
  logic [7:0] scan_mask_reg, scan_mask_next;
  logic [7:0] alarm_mask_reg, alarm_mask_next;
  logic [7:0] alarm_map_reg, alarm_map_next;
  logic [7:0] pin_function_reg, pin_function_next;
  logic [IRQ_W-1:0] irq_status_reg, irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic alarm_next, irq_next;
  logic crossing_src_next;
  logic crossing_src_reg;
  logic [CHAN_CODE_W-1:0] seq_channel;
  logic seq_active, seq_wrapped;
  logic hold_event, hold_blank;
  logic [7:0] widx;
  logic wr_en, rd_en, hit;
  logic [CHAN_CODE_W-1:0] cross_code;
  logic [IRQ_W-1:0] events;

  function automatic logic idx_known(input logic [7:0] idx);
    idx_known = (idx == IDX_HOLDOFF) || (idx == IDX_SCAN_CONFIG) ||
                (idx == IDX_CHANNEL_PICK) || (idx == IDX_SCAN_MASK) ||
                (idx == IDX_ALARM_MASK) || (idx == IDX_ALARM_MAP) ||
                (idx == IDX_PIN_FUNCTION) || (idx == IDX_IRQ_STATUS) ||
                (idx == IDX_IRQ_MASK) || (idx == IDX_SCAN_STATE);
  endfunction : idx_known

  // ************************************************************
  // sub-blocks
  // ************************************************************
  ascc_sequencer u_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scan_mode_select(scan_config_reg[1:0]),
    .scan_run(scan_config_reg[RUN_BIT]),
    .scan_channel_bits(scan_mask_reg),
    .host_channel_code(channel_pick_reg[3:0]),
    .fly_channel_code(fly_channel_code),
    .conv_done(conv_done),
    .next_channel(seq_channel),
    .scan_active(seq_active),
    .wrapped(seq_wrapped)
  );

  ascc_holdoff u_hold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .holdoff_cfg(holdoff_reg),
    .crossing_channel_code(cross_code),
    .conv_done(conv_done),
    .conv_channel(conv_channel),
    .raw_crossing(crossing_src_reg),
    .crossing_event(hold_event),
    .blanking(hold_blank)
  );

  assign cross_code = channel_pick_reg[7:4];
  assign widx = paddr[ADDR_W-1:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit = idx_known(widx) && (paddr[1:0] == 2'h0);
  assign events = {(cross_code >= CHAN_CODE_W'(NCH)), seq_wrapped, hold_event};

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    holdoff_next = holdoff_reg;
    scan_config_next = scan_config_reg;
    channel_pick_next = channel_pick_reg;
    scan_mask_next = scan_mask_reg;
    alarm_mask_next = alarm_mask_reg;
    alarm_map_next = alarm_map_reg;
    pin_function_next = pin_function_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    prdata_next = '0;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pready_next = 1'b1;
      pslverr_next = !hit;
    end
    if (wr_en && pready && hit) begin
      if (widx == IDX_HOLDOFF) begin
        holdoff_next = pwdata[7:0];
      end else if (widx == IDX_SCAN_CONFIG) begin
        scan_config_next = pwdata[7:0] & SCAN_CONFIG_WMASK;
      end else if (widx == IDX_CHANNEL_PICK) begin
        channel_pick_next = pwdata[7:0];
      end else if (widx == IDX_SCAN_MASK) begin
        scan_mask_next = pwdata[7:0];
      end else if (widx == IDX_ALARM_MASK) begin
        alarm_mask_next = pwdata[7:0];
      end else if (widx == IDX_ALARM_MAP) begin
        alarm_map_next = pwdata[7:0] & ALARM_MAP_WMASK;
      end else if (widx == IDX_PIN_FUNCTION) begin
        pin_function_next = pwdata[7:0];
      end else if (widx == IDX_IRQ_STATUS) begin
        irq_status_next = irq_status_reg & ~pwdata[IRQ_W-1:0];
      end else if (widx == IDX_IRQ_MASK) begin
        irq_mask_next = pwdata[IRQ_W-1:0];
      end
    end
    irq_status_next = irq_status_next | events;
    if (rd_en && hit) begin
      if (widx == IDX_HOLDOFF) begin
        prdata_next = {24'h0, holdoff_reg};
      end else if (widx == IDX_SCAN_CONFIG) begin
        prdata_next = {24'h0, scan_config_reg & SCAN_CONFIG_WMASK};
      end else if (widx == IDX_CHANNEL_PICK) begin
        prdata_next = {24'h0, channel_pick_reg};
      end else if (widx == IDX_SCAN_MASK) begin
        prdata_next = {24'h0, scan_mask_reg};
      end else if (widx == IDX_ALARM_MASK) begin
        prdata_next = {24'h0, alarm_mask_reg};
      end else if (widx == IDX_ALARM_MAP) begin
        prdata_next = {24'h0, alarm_map_reg};
      end else if (widx == IDX_PIN_FUNCTION) begin
        prdata_next = {24'h0, pin_function_reg};
      end else if (widx == IDX_IRQ_STATUS) begin
        prdata_next = {29'h0, irq_status_reg};
      end else if (widx == IDX_IRQ_MASK) begin
        prdata_next = {29'h0, irq_mask_reg};
      end else begin
        prdata_next = {26'h0, hold_blank, seq_active, seq_channel};
      end
    end
    if (cross_code >= CHAN_CODE_W'(NCH)) begin
      crossing_src_next = 1'b0;
    end else if (pin_function_reg[cross_code[2:0]]) begin
      crossing_src_next = pin_level[cross_code[2:0]];
    end else begin
      crossing_src_next = analog_crossing[cross_code[2:0]];
    end
    alarm_next = |(alarm_flags & alarm_mask_reg[NCH-1:0]);
    irq_next = |(irq_status_reg & irq_mask_reg);
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdoff_reg <= RESET_BYTE;
      scan_config_reg <= RESET_BYTE;
      channel_pick_reg <= RESET_BYTE;
      scan_mask_reg <= RESET_BYTE;
      alarm_mask_reg <= RESET_BYTE;
      alarm_map_reg <= RESET_BYTE;
      pin_function_reg <= RESET_BYTE;
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      next_channel <= '0;
      scan_active <= 1'b0;
      zero_crossing_detect <= 1'b0;
      crossing_blanking <= 1'b0;
      crossing_src_reg <= 1'b0;
      alarm_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      holdoff_reg <= holdoff_next;
      scan_config_reg <= scan_config_next;
      channel_pick_reg <= channel_pick_next;
      scan_mask_reg <= scan_mask_next;
      alarm_mask_reg <= alarm_mask_next;
      alarm_map_reg <= alarm_map_next;
      pin_function_reg <= pin_function_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      next_channel <= seq_channel;
      scan_active <= seq_active;
      zero_crossing_detect <= hold_event;
      crossing_blanking <= hold_blank;
      crossing_src_reg <= crossing_src_next;
      alarm_out <= alarm_next;
      irq <= irq_next;
    end
  end
endmodule : ascc_top

/* File: ascc_pkg.sv */
// package of register offsets, field positions and reset values for the scan and crossing block
// assumes an apb slave with 32-bit data and one aligned word per register
package ascc_pkg;
  // ************************************************************
  // register indexes (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_HOLDOFF = 8'h0f;
  localparam logic [7:0] IDX_SCAN_CONFIG = 8'h10;
  localparam logic [7:0] IDX_CHANNEL_PICK = 8'h11;
  localparam logic [7:0] IDX_SCAN_MASK = 8'h12;
  localparam logic [7:0] IDX_ALARM_MASK = 8'h14;
  localparam logic [7:0] IDX_ALARM_MAP = 8'h16;
  localparam logic [7:0] IDX_PIN_FUNCTION = 8'h05;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_SCAN_STATE = 8'h22;
  localparam int ADDR_W = 10;
  // ************************************************************
  // field positions and widths
  // ************************************************************
  localparam int MULT_BIT = 7;
  localparam int HOLDOFF_W = 7;
  localparam int HOLDOFF_MULT_SHIFT = 3;
  localparam int CNT_W = 10;
  localparam int RUN_BIT = 4;
  localparam logic [7:0] SCAN_CONFIG_WMASK = 8'h13;
  localparam logic [7:0] ALARM_MAP_WMASK = 8'h03;
  localparam int CHAN_CODE_W = 4;
  localparam int NUM_CHAN = 8;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ************************************************************
  // interrupt status bits
  // ************************************************************
  localparam int IRQ_CROSSING = 0;
  localparam int IRQ_SCAN_WRAP = 1;
  localparam int IRQ_BAD_CODE = 2;
  localparam int IRQ_W = 3;
  // ************************************************************
  // scan modes
  // ************************************************************
  typedef enum logic [1:0] {
    ASCC_MODE_MANUAL = 2'h0,
    ASCC_MODE_AUTO = 2'h1,
    ASCC_MODE_ON_THE_FLY = 2'h2,
    ASCC_MODE_RESERVED = 2'h3
  } ascc_mode_t;
endpackage : ascc_pkg

/* File: ascc_holdoff.sv */
// hold-off counter that blanks crossing events for a number of conversions
// assumes conv_done pulses once per conversion with conv_channel valid
`timescale 1ns/1ns
module ascc_holdoff
  import ascc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] holdoff_cfg,
  input wire logic [CHAN_CODE_W-1:0] crossing_channel_code,
  input wire logic conv_done,
  input wire logic [CHAN_CODE_W-1:0] conv_channel,
  input wire logic raw_crossing,
  output logic crossing_event,
  output logic blanking
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] load_value;
  logic crossing_event_next;
  logic on_chan;

  always_comb begin
    if (holdoff_cfg[MULT_BIT]) begin
      load_value = CNT_W'({holdoff_cfg[HOLDOFF_W-1:0], 3'h0});
    end else begin
      load_value = CNT_W'(holdoff_cfg[HOLDOFF_W-1:0]);
    end
    on_chan = conv_done && (conv_channel == crossing_channel_code);
    count_next = count_reg;
    crossing_event_next = 1'b0;
    if (on_chan) begin
      if (count_reg != '0) begin
        count_next = count_reg - CNT_W'(1);
      end else if (raw_crossing) begin
        crossing_event_next = 1'b1;
        count_next = load_value;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      crossing_event <= 1'b0;
    end else begin
      count_reg <= count_next;
      crossing_event <= crossing_event_next;
    end
  end

  assign blanking = (count_reg != '0);
endmodule : ascc_holdoff

/* File: ascc_sequencer.sv */
// channel sequencer picking the next conversion channel by scan mode
// assumes conv_done pulses when the converter finishes the current channel
`timescale 1ns/1ns
module ascc_sequencer
  import ascc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] scan_mode_select,
  input wire logic scan_run,
  input wire logic [NUM_CHAN-1:0] scan_channel_bits,
  input wire logic [CHAN_CODE_W-1:0] host_channel_code,
  input wire logic [CHAN_CODE_W-1:0] fly_channel_code,
  input wire logic conv_done,
  output logic [CHAN_CODE_W-1:0] next_channel,
  output logic scan_active,
  output logic wrapped
);
  logic [CHAN_CODE_W-1:0] ptr_reg;
  logic [CHAN_CODE_W-1:0] ptr_next;
  logic wrap_next;
  logic found_up;
  logic [CHAN_CODE_W-1:0] up_ch;
  logic [CHAN_CODE_W-1:0] low_ch;

  always_comb begin
    found_up = 1'b0;
    up_ch = '0;
    low_ch = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (scan_channel_bits[i]) begin
        low_ch = CHAN_CODE_W'(i);
      end
      if (scan_channel_bits[i] && (CHAN_CODE_W'(i) > ptr_reg)) begin
        found_up = 1'b1;
        up_ch = CHAN_CODE_W'(i);
      end
    end
    scan_active = (scan_mode_select == ASCC_MODE_AUTO) && scan_run && (scan_channel_bits != '0);
    ptr_next = ptr_reg;
    wrap_next = 1'b0;
    if (!scan_active) begin
      ptr_next = low_ch;
    end else if (!scan_channel_bits[ptr_reg[2:0]] || ptr_reg >= CHAN_CODE_W'(NUM_CHAN)) begin
      ptr_next = found_up ? up_ch : low_ch;
    end else if (conv_done) begin
      ptr_next = found_up ? up_ch : low_ch;
      wrap_next = !found_up;
    end
    case (scan_mode_select)
      ASCC_MODE_MANUAL: next_channel = host_channel_code;
      ASCC_MODE_AUTO: next_channel = ptr_reg;
      ASCC_MODE_ON_THE_FLY: next_channel = fly_channel_code;
      default: next_channel = host_channel_code;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= '0;
      wrapped <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      wrapped <= wrap_next;
    end
  end
endmodule : ascc_sequencer

/* File: ascc_top_asserts.sv */
// port-level assertions for ascc_top
// assumes binding to ascc_top and sight of its ports only
`timescale 1ns/1ns
module ascc_top_asserts
  import ascc_pkg::*;
#(
  parameter int NCH = NUM_CHAN
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_done,
  input wire logic [CHAN_CODE_W-1:0] conv_channel,
  input wire logic [NCH-1:0] analog_crossing,
  input wire logic [NCH-1:0] pin_level,
  input wire logic [NCH-1:0] alarm_flags,
  input wire logic [CHAN_CODE_W-1:0] fly_channel_code,
  input wire logic [CHAN_CODE_W-1:0] next_channel,
  input wire logic scan_active,
  input wire logic zero_crossing_detect,
  input wire logic crossing_blanking,
  input wire logic alarm_out,
  input wire logic irq
);
  // ****************
  // assertions
  // ****************
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic wr;
  wire logic rd_cfg;
  assign wr = psel & penable & pwrite & pready;
  assign rd_cfg = psel & penable & !pwrite & pready & (paddr == {IDX_SCAN_CONFIG, 2'b00});
  AST_RESV_ZERO: assert property (rd_cfg |-> (prdata & 32'hffffffec) == 32'h0)
    else $error("reserved scan config bits read nonzero");
  AST_READY_ONE: assert property (pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  AST_ALARM_QUIET: assert property ($past(alarm_flags) == '0 && $past(alarm_flags, 2) == '0
    |-> !alarm_out)
    else $error("alarm with no flags");
  AST_XING_CONV: assert property (zero_crossing_detect |-> $past(conv_done) ||
    $past(conv_done, 2))
    else $error("crossing event without conversion");
  AST_BLANK_RISE: assert property ($rose(crossing_blanking) |-> zero_crossing_detect ||
    $past(zero_crossing_detect))
    else $error("blanking began without crossing event");
  AST_BLANK_FALL: assert property ($fell(crossing_blanking) |-> $past(conv_done) ||
    $past(conv_done, 2) || $past(conv_done, 3))
    else $error("blanking ended without conversion");
  AST_SCAN_START: assert property ($rose(scan_active) |-> $past(wr) || $past(wr, 2) ||
    $past(wr, 3))
    else $error("scan started without a write");
  AST_SCAN_STOP: assert property ($fell(scan_active) |-> $past(wr) || $past(wr, 2) ||
    $past(wr, 3))
    else $error("scan stopped without a write");
  CV_XING: cover property (zero_crossing_detect);
  CV_SCAN: cover property ($rose(scan_active));
  CV_IRQ: cover property (irq);
  CV_ERR: cover property (pslverr);
endmodule : ascc_top_asserts

bind ascc_top ascc_top_asserts #(.NCH(NCH)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_done(conv_done), .conv_channel(conv_channel), .analog_crossing(analog_crossing),
  .pin_level(pin_level), .alarm_flags(alarm_flags), .fly_channel_code(fly_channel_code),
  .next_channel(next_channel), .scan_active(scan_active), .irq(irq),
  .zero_crossing_detect(zero_crossing_detect), .crossing_blanking(crossing_blanking),
  .alarm_out(alarm_out)
);

/* File: ascc_top_tb_top.sv */
// self-checking testbench for ascc_top
// assumes the checker is bound in separately
`timescale 1ns/1ns
module ascc_top_tb_top;
  import ascc_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, conv_done, pready, pslverr, erv, h;
  logic scan_active, zero_crossing_detect, crossing_blanking, alarm_out, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [CHAN_CODE_W-1:0] conv_channel, fly_channel_code, next_channel, e;
  logic [NUM_CHAN-1:0] analog_crossing, pin_level, alarm_flags;
  logic [7:0] regs [10] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h14, 8'h16, 8'h05, 8'h20, 8'h21, 8'h22};
  logic [3:0] mexp [4] = '{4'h5, 4'h0, 4'h6, 4'h5};
  int error_cnt, cmp_count, cyc, n;
  ascc_top dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_channel(conv_channel), .analog_crossing(analog_crossing),
    .pin_level(pin_level), .alarm_flags(alarm_flags), .fly_channel_code(fly_channel_code),
    .next_channel(next_channel), .scan_active(scan_active), .irq(irq),
    .zero_crossing_detect(zero_crossing_detect), .crossing_blanking(crossing_blanking),
    .alarm_out(alarm_out)
  );
  // ****************
  // tasks
  // ****************
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++k < 20);
    if (k >= 20) error_cnt++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask : rd
  // one conversion, reporting whether a crossing event followed
  task automatic conv(input logic [3:0] ch);
    h = 1'b0;
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_channel <= ch;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (3) begin
      @(posedge core_clk);
      h = h | zero_crossing_detect;
    end
  endtask : conv
  function automatic logic [3:0] nxt(input logic [7:0] m, input logic [3:0] c);
    logic [3:0] j;
    j = c;
    for (int k = 0; k < 8; k++) begin
      j = (j + 4'h1) & 4'h7;
      if (m[j[2:0]]) return j;
    end
    return c;
  endfunction : nxt
  // ****************
  // stimulus
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, conv_done, paddr, pwdata, conv_channel} = '0;
    {fly_channel_code, analog_crossing, pin_level, alarm_flags} = '0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0);
    apb(1'b1, IDX_SCAN_CONFIG, 32'hff);
    rd(IDX_SCAN_CONFIG, 32'h13);
    apb(1'b0, 8'h3f, 32'h0);
    chk({31'h0, erv}, 32'h1);
    chk(rdv, 32'h0);
    apb(1'b1, IDX_CHANNEL_PICK, 32'h05);
    fly_channel_code <= 4'h6;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, IDX_SCAN_CONFIG, 32'(m));
      repeat (4) @(posedge core_clk);
      chk(next_channel, mexp[m]);
    end
    apb(1'b1, IDX_SCAN_MASK, 32'h29);
    apb(1'b1, IDX_SCAN_CONFIG, 32'h11);
    repeat (4) @(posedge core_clk);
    chk(scan_active, 1'b1);
    e = 4'h0;
    for (int i = 0; i < 7; i++) begin
      chk(next_channel, e);
      conv(e);
      e = nxt(8'h29, e);
    end
    apb(1'b1, IDX_SCAN_CONFIG, 32'h01);
    repeat (4) @(posedge core_clk);
    chk(scan_active, 1'b0);
    rd(IDX_IRQ_STATUS, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, IDX_IRQ_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1);
    apb(1'b1, IDX_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    apb(1'b1, IDX_CHANNEL_PICK, 32'h20);
    analog_crossing <= 8'h04;
    for (int k = 0; k < 2; k++) begin
      n = k ? 8 : 2;
      apb(1'b1, IDX_HOLDOFF, k ? 32'h81 : 32'h02);
      for (int i = 0; i < 2 * n + 2; i++) begin
        conv(4'h1);
        chk(h, 1'b0);
        conv(4'h2);
        chk(h, i % (n + 1) == 0);
        chk(crossing_blanking, i % (n + 1) != n);
      end
    end
    apb(1'b1, IDX_HOLDOFF, 32'h0);
    analog_crossing <= 8'hfb;
    conv(4'h2);
    chk(h, 1'b0);
    apb(1'b1, IDX_PIN_FUNCTION, 32'h04);
    analog_crossing <= 8'hff;
    repeat (2) @(posedge core_clk);
    conv(4'h2);
    chk(h, 1'b0);
    pin_level <= 8'h04;
    analog_crossing <= 8'h00;
    repeat (2) @(posedge core_clk);
    conv(4'h2);
    chk(h, 1'b1);
    apb(1'b1, IDX_ALARM_MASK, 32'h0f);
    alarm_flags <= 8'hf0;
    repeat (3) @(posedge core_clk);
    chk(alarm_out, 1'b0);
    alarm_flags <= 8'h12;
    repeat (3) @(posedge core_clk);
    chk(alarm_out, 1'b1);
    report_and_stop();
  end
endmodule : ascc_top_tb_top
